// *** logic/bus_phy_mode_config.sv ***
// Bus and physical layer mode configuration register with hidden write
//
// Functional notes
// - Bits 1:0 select twisted pair or AUI.
// - Coax pin low thick, high thin.
// - One twisted-pair mode lowers squelch levels.
// - Bit 2 set disables link pulses, checks.
// - Link status read equals link LED.
// - Status zero for AUI or failed link.
// - Status one if good link or disabled, twisted pair only.
// - Bit 3 high: wide I/O after command.
// - Bit 3 low: wide I/O from decode.
// - Bit 4 low: ready after command strobe.
// - Bit 4 high: ready after address latch.
// - Bus error set on ignored waits.
// - Write one clears bus error flag.
// - Bit 6 low blocks boot PROM writes.
// - Writing bit 7 starts EEPROM load.
// - Write lands only after same read.
`include "bus_phy_defs.svh"

module bus_phy_mode_config
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire bus_phy_pkg::reg_req_t req,
  output logic [7:0] rdata,
  output logic hi_count_wr,
  output logic [7:0] hi_count_data,
  input wire logic link_good,
  input wire logic io_decode,
  input wire logic io_cmd_active,
  input wire logic ale_rise,
  input wire logic cmd_strobe,
  input wire logic wait_ignored,
  input wire logic boot_wr_req,
  output logic boot_wr_out,
  output logic wide_io_out,
  output logic chrdy_start,
  output logic link_led,
  output logic eeprom_load_start,
  output bus_phy_pkg::phy_ctl_t phy_ctl
);
  import bus_phy_pkg::*;

  cfg_state_t st_ff;
  cfg_state_t nxt_st;
  phy_ctl_t nxt_phy;
  logic is_tp;
  logic link_good_sync;
  logic link_status_ctl;
  logic hit;
  logic rd_hit;
  logic wr_hit;
  logic [7:0] rd_word;

  ////////////////////////////////////////////////////////////////////////
  // Link integrity from the transceiver, resynchronised
  pin_sync3 i_pin_sync3
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(link_good),
    .level_out(link_good_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Physical interface decode
  // Two selections drive the twisted-pair pins, two the AUI pins
  always_comb
  begin
    nxt_phy = '0;
    case (st_ff.phy_select)
      PHY_TP_STD:
      begin
        nxt_phy.tp_enable = 1'b1;
      end
      PHY_AUI_THICK:
      begin
        nxt_phy.aui_enable = 1'b1;
        nxt_phy.coax_mode = 1'b0;
      end
      PHY_AUI_THIN:
      begin
        nxt_phy.aui_enable = 1'b1;
        nxt_phy.coax_mode = 1'b1;
      end
      PHY_TP_LOWSQ:
      begin
        nxt_phy.tp_enable = 1'b1;
        nxt_phy.low_squelch = 1'b1;
      end
      default:
      begin
        nxt_phy.tp_enable = 1'b1;
      end
    endcase

    nxt_phy.link_test_en = nxt_phy.tp_enable && !st_ff.link_disable;
  end

  assign phy_ctl = nxt_phy;
  assign is_tp = nxt_phy.tp_enable;

  ////////////////////////////////////////////////////////////////////////
  // Link status shown on the LED and read back
  // AUI reads zero; disabled testing reads one on twisted pair only
  always_comb
  begin
    case ({is_tp, st_ff.link_disable})
      2'b10:
      begin
        link_status_ctl = link_good_sync;
      end
      2'b11:
      begin
        link_status_ctl = 1'b1;
      end
      default:
      begin
        link_status_ctl = 1'b0;
      end
    endcase
  end

  assign link_led = link_status_ctl;

  ////////////////////////////////////////////////////////////////////////
  // Bus timing selections
  always_comb
  begin
    if (st_ff.wide_io_timing_sel)
    begin
      wide_io_out = io_decode && io_cmd_active;
    end
    else
    begin
      wide_io_out = io_decode;
    end

    if (st_ff.chrdy_from_ale)
    begin
      chrdy_start = ale_rise;
    end
    else
    begin
      chrdy_start = cmd_strobe;
    end
  end

  assign boot_wr_out = boot_wr_req && st_ff.boot_rom_write_en;
  assign eeprom_load_start = st_ff.eeprom_load_trigger;

  ////////////////////////////////////////////////////////////////////////
  // Read-back word
  // Bit 2 shows link status, not the written link control
  always_comb
  begin
    rd_word = '0;
    rd_word[`BIT_PHY_HI:`BIT_PHY_LO] = st_ff.phy_select;
    rd_word[`BIT_LINK] = link_status_ctl;
    rd_word[`BIT_WIDE_IO] = st_ff.wide_io_timing_sel;
    rd_word[`BIT_CHRDY] = st_ff.chrdy_from_ale;
    rd_word[`BIT_BUS_ERR] = st_ff.bus_error_flag;
    rd_word[`BIT_BOOT_WR] = st_ff.boot_rom_write_en;
    rd_word[`BIT_EE_LOAD] = st_ff.eeprom_load_trigger;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register access and hidden write sequence
  // Any other strobe disarms, so a stray access diverts the write
  assign hit = req.strobe && req.page0 && (req.addr == `CFG_B_OFFSET);
  assign rd_hit = hit && !req.wr;
  assign wr_hit = hit && req.wr;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.hi_count_wr = 1'b0;
    nxt_st.eeprom_load_trigger = 1'b0;

    if (req.strobe)
    begin
      if (rd_hit)
      begin
        nxt_st.unlock = SEQ_ARMED;
      end
      else
      begin
        nxt_st.unlock = SEQ_IDLE;
      end
    end
    if (rd_hit)
    begin
      nxt_st.rdata = rd_word;
    end

    // Armed writes land, others go to the count register
    if (wr_hit && (st_ff.unlock == SEQ_ARMED))
    begin
      nxt_st.phy_select =
        phy_sel_t'(req.wdata[`BIT_PHY_HI:`BIT_PHY_LO]);
      nxt_st.link_disable = req.wdata[`BIT_LINK];
      nxt_st.wide_io_timing_sel = req.wdata[`BIT_WIDE_IO];
      nxt_st.chrdy_from_ale = req.wdata[`BIT_CHRDY];
      nxt_st.boot_rom_write_en = req.wdata[`BIT_BOOT_WR];
      nxt_st.eeprom_load_trigger = req.wdata[`BIT_EE_LOAD];
      if (req.wdata[`BIT_BUS_ERR])
      begin
        nxt_st.bus_error_flag = 1'b0;
      end
    end
    else if (wr_hit)
    begin
      nxt_st.hi_count_wr = 1'b1;
      nxt_st.hi_count_data = req.wdata;
    end

    // Set wins over a clear in the same cycle
    if (wait_ignored)
    begin
      nxt_st.bus_error_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '{
        unlock: SEQ_IDLE,
        phy_select: PHY_TP_STD,
        link_disable: 1'b0,
        wide_io_timing_sel: 1'b0,
        chrdy_from_ale: 1'b0,
        bus_error_flag: 1'b0,
        boot_rom_write_en: 1'b0,
        eeprom_load_trigger: 1'b0,
        rdata: `CFG_B_RESET,
        hi_count_wr: 1'b0,
        hi_count_data: 8'h00
      };
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  assign rdata = st_ff.rdata;
  assign hi_count_wr = st_ff.hi_count_wr;
  assign hi_count_data = st_ff.hi_count_data;
endmodule

////////////////////////////////////////////////////////////////////////
// Three-stage synchroniser for an asynchronous pin
module pin_sync3
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level_out
);
  import bus_phy_pkg::*;

  pin_sync_t sync_ff;
  pin_sync_t nxt_sync;

  // Stage one may go metastable; a level counts only once
  // the second and third stages agree
  always_comb
  begin
    nxt_sync = sync_ff;
    nxt_sync.stage = {sync_ff.stage[1:0], pin_in};

    if (sync_ff.stage[1] == sync_ff.stage[2])
    begin
      nxt_sync.level = sync_ff.stage[2];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_ff <= '{
        stage: 3'h0,
        level: 1'b0
      };
    end
    else
    begin
      sync_ff <= nxt_sync;
    end
  end

  assign level_out = sync_ff.level;
endmodule

// *** logic/bus_phy_defs.svh ***
// Constants for the bus and physical layer configuration register
`ifndef BUS_PHY_DEFS_SVH
`define BUS_PHY_DEFS_SVH
`define CFG_B_OFFSET 4'hb
`define CFG_B_RESET 8'h00
`define BIT_PHY_LO 0
`define BIT_PHY_HI 1
`define BIT_LINK 2
`define BIT_WIDE_IO 3
`define BIT_CHRDY 4
`define BIT_BUS_ERR 5
`define BIT_BOOT_WR 6
`define BIT_EE_LOAD 7
`endif

// *** logic/bus_phy_pkg.sv ***
// Types for the bus and physical layer configuration register
package bus_phy_pkg;
  typedef enum logic [1:0] {
    PHY_TP_STD = 2'b00,
    PHY_AUI_THICK = 2'b01,
    PHY_AUI_THIN = 2'b10,
    PHY_TP_LOWSQ = 2'b11
  } phy_sel_t;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_ARMED = 1'b1
  } unlock_st_t;

  typedef struct packed {
    logic strobe;
    logic wr;
    logic page0;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic tp_enable;
    logic aui_enable;
    logic coax_mode;
    logic low_squelch;
    logic link_test_en;
  } phy_ctl_t;

  typedef struct packed {
    unlock_st_t unlock;
    phy_sel_t phy_select;
    logic link_disable;
    logic wide_io_timing_sel;
    logic chrdy_from_ale;
    logic bus_error_flag;
    logic boot_rom_write_en;
    logic eeprom_load_trigger;
    logic [7:0] rdata;
    logic hi_count_wr;
    logic [7:0] hi_count_data;
  } cfg_state_t;

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } pin_sync_t;
endpackage

// *** verification/isa_host_model.sv ***
// Host bus model: repeating I/O cycles with an optional ignored wait
module isa_host_model (
  input wire logic sys_clk, rst_n, cut,
  output logic ale_rise, cmd_strobe, io_decode, io_cmd_active, wait_ignored
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph_ff;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_ff <= 2'h0;
    end
    else
    begin
      ph_ff <= ph_ff + 2'h1;
    end
  end
  assign ale_rise = ph_ff == 2'h1;
  assign cmd_strobe = ph_ff == 2'h2;
  assign io_decode = ph_ff != 2'h0;
  assign io_cmd_active = ph_ff[1];
  assign wait_ignored = cut && ph_ff == 2'h3;
endmodule

// *** verification/bus_phy_asserts.sv ***
// Port checker for the configuration register
module bus_phy_asserts (
  input wire logic sys_clk, rst_n, hi_count_wr, eeprom_load_start,
  input wire logic io_decode, ale_rise, cmd_strobe, wide_io_out,
  input wire logic chrdy_start, link_led,
  input wire bus_phy_pkg::reg_req_t req,
  input wire bus_phy_pkg::phy_ctl_t phy_ctl
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_wd; wide_io_out |-> io_decode; endproperty
  a_wd: assert property (p_wd) else $error("wd");
  property p_rd; chrdy_start |-> ale_rise || cmd_strobe; endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_hc; hi_count_wr |-> $past(req.wr); endproperty
  a_hc: assert property (p_hc) else $error("hc");
  property p_ee; eeprom_load_start |-> $past(req.wdata[7]); endproperty
  a_ee: assert property (p_ee) else $error("ee");
  property p_cx; phy_ctl.coax_mode |-> phy_ctl.aui_enable; endproperty
  a_cx: assert property (p_cx) else $error("cx");
  property p_sq; phy_ctl.low_squelch |-> phy_ctl.tp_enable; endproperty
  a_sq: assert property (p_sq) else $error("sq");
  property p_au; phy_ctl.aui_enable |-> !link_led; endproperty
  a_au: assert property (p_au) else $error("au");
  property p_tp; phy_ctl.tp_enable != phy_ctl.aui_enable; endproperty
  a_tp: assert property (p_tp) else $error("tp");
  c_hc: cover property (hi_count_wr);
  c_ee: cover property (eeprom_load_start);
  c_rd: cover property (chrdy_start && ale_rise);
endmodule
bind bus_phy_mode_config bus_phy_asserts i_bus_phy_asserts (.*);

// *** verification/test_bus_phy_mode_config.sv ***
// Configuration register testbench
module test_bus_phy_mode_config;
  import bus_phy_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rst_n = 0, link_good = 0, cut = 0, boot_wr_req = 1;
  logic ale_rise, cmd_strobe, io_decode, io_cmd_active, wait_ignored, t;
  logic hi_count_wr, boot_wr_out, wide_io_out, chrdy_start, link_led;
  logic eeprom_load_start;
  logic [7:0] rdata, hi_count_data;
  reg_req_t req = '0;
  phy_ctl_t phy_ctl;
  int n_fail = 0, compares = 0;
  always #12.5 sys_clk = ~sys_clk;
  isa_host_model i_isa_host_model (.*);
  bus_phy_mode_config i_bus_phy_mode_config (.*);
  task chk(input logic [15:0] s, e);
    compares++;
    n_fail += s !== e;
    if (s !== e) $display("[ERR] %0t %h %h", $time, s, e);
  endtask
  task acc(input logic w, input logic [7:0] d);
    @(posedge sys_clk) req <= '{1'b1, w, 1'b1, 4'hb, d};
    @(posedge sys_clk) req.strobe <= 1'b0;
    #1;
  endtask
  task bus(input logic [2:0] a, b);
    @(posedge ale_rise) #1 chk({wide_io_out, chrdy_start, boot_wr_out}, a);
    @(posedge cmd_strobe) #1 chk({wide_io_out, chrdy_start, boot_wr_out}, b);
  endtask
  task results(input int f);
    n_fail += f;
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial #100us results(1);
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    acc(1, 8'h55);
    chk({hi_count_wr, hi_count_data}, 16'h155);
    acc(0, 0);
    acc(1, 8'h04);
    chk({link_led, phy_ctl.link_test_en}, 2'b10);
    for (int i = 0; i < 4; i++)
    begin
      t = i % 3 == 0;
      acc(0, 0);
      acc(1, 8'(i));
      chk({phy_ctl, link_led}, {t, !t, i==2, i==3, t, 1'b0});
    end
    acc(0, 0);
    @(posedge sys_clk) {cut, link_good} <= 2'b11;
    acc(1, 8'h58);
    bus(3'b011, 3'b101);
    repeat (2) @(posedge sys_clk);
    cut <= 1'b0;
    acc(0, 0);
    acc(1, 8'h00);
    bus(3'b100, 3'b110);
    acc(0, 0);
    chk(rdata[5], 1);
    acc(1, 8'ha0);
    chk({eeprom_load_start, link_led}, 2'b11);
    acc(0, 0);
    chk({rdata[5], rdata[2], link_led}, 3'b011);
    results(0);
  end
endmodule
